// *** hw/emp_pkg.sv ***
// package for the external memory port controller
package emp_pkg;
    // register offsets (word addresses on the plain register port)
    localparam logic [3:0] EMP_REG_BANK0 = 4'h0;
    localparam logic [3:0] EMP_REG_BANK1 = 4'h1;
    localparam logic [3:0] EMP_REG_BANK2 = 4'h2;
    localparam logic [3:0] EMP_REG_BANK3 = 4'h3;
    localparam logic [3:0] EMP_REG_BOOT = 4'h4;
    localparam logic [3:0] EMP_REG_IO = 4'h5;
    localparam logic [3:0] EMP_REG_PAGES10 = 4'h6;
    localparam logic [3:0] EMP_REG_PAGES32 = 4'h7;
    localparam logic [3:0] EMP_REG_CTL = 4'h8;
    localparam logic [3:0] EMP_REG_WSTAT = 4'h9;
    localparam logic [3:0] EMP_REG_BSTAT = 4'hA;
    // region control field positions
    localparam int EMP_RWC_LSB = 0;
    localparam int EMP_WWC_LSB = 3;
    localparam int EMP_WMS_LSB = 6;
    localparam int EMP_CDS_LSB = 8;
    localparam int EMP_WHE_BIT = 11;
    // status and bus lock field positions
    localparam int EMP_WPF_BIT = 8;
    localparam int EMP_BSY_LSB = 0;
    localparam int EMP_MID_LSB = 2;
    localparam int EMP_WPS_LSB = 7;
    localparam int EMP_BL_BIT = 0;
    // reset values
    localparam logic [15:0] EMP_RCTL_RST = 16'h0000;
    localparam logic [7:0] EMP_PG0_RST = 8'h01;
    localparam logic [7:0] EMP_PG1_RST = 8'h40;
    localparam logic [7:0] EMP_PG2_RST = 8'h80;
    localparam logic [7:0] EMP_PG3_RST = 8'hC0;
    // waitstate modes
    localparam logic [1:0] EMP_WMS_ACK = 2'h0;
    localparam logic [1:0] EMP_WMS_WAIT = 2'h1;
    localparam logic [1:0] EMP_WMS_BOTH = 2'h2;
    localparam logic [1:0] EMP_WMS_EITHER = 2'h3;
    localparam logic [2:0] EMP_ACK_MIN_WS = 3'h2;
    localparam logic [2:0] EMP_CDS_MAX = 3'h5;
    // bus owner codes
    localparam logic [1:0] EMP_BSY_IDLE = 2'h0;
    localparam logic [1:0] EMP_BSY_OFF = 2'h1;
    localparam logic [1:0] EMP_BSY_ON = 2'h2;
    // master ids (arbitrary values)
    localparam logic [4:0] EMP_MID_CORE = 5'h01;
    localparam logic [4:0] EMP_MID_EXT = 5'h1F;
    // region index
    localparam logic [2:0] EMP_RGN_BOOT = 3'h4;
    localparam logic [2:0] EMP_RGN_IO = 3'h5;

    typedef enum logic [4:0] {
        EMP_IDLE = 5'b00001,
        EMP_STROBE = 5'b00010,
        EMP_HOLD = 5'b00100,
        EMP_GRANT = 5'b01000,
        EMP_GAP = 5'b10000
    } emp_state_e;

    // one access request from the core
    typedef struct packed {
        logic [2:0] space;
        logic write;
        logic [21:0] addr;
        logic [15:0] data;
    } emp_req_s;

    // external pin group
    typedef struct packed {
        logic [21:0] addr;
        logic [15:0] data;
        logic rd_n;
        logic wr_n;
        logic [3:0] bank_sel_n;
        logic boot_sel_n;
        logic io_sel_n;
    } emp_pins_s;
endpackage

// *** hw/emp_ctrl.sv ***
// external memory port controller: waitstates, clocks, banks, arbitration
// Operation
// RULE1 - count fields give zero to seven waitstates
// RULE2 - mode zero ends on ack, two minimum
// RULE3 - mode one uses count only
// RULE4 - mode two needs count and ack
// RULE5 - mode three ends on count or ack
// RULE6 - write hold keeps address, data one cycle
// RULE7 - hold applies in every mode
// RULE8 - divider ratios one to thirty two
// RULE9 - four banks, reprogrammable lower page
// RULE10 - bank zero at 0x10000, select matching bank
// RULE11 - write pending flag at bit eight
// RULE12 - bus owner state in bits one-zero
// RULE13 - last master id in bits six-two
// RULE14 - packer byte count in bits eight-seven; the code always reads zero there
// RULE15 - writes posted without stalling core
// RULE16 - idle request floats pins, grants next cycle
// RULE17 - core stalls only on external access
// RULE18 - grant after current access completes
// RULE19 - grant between two accesses
// RULE20 - request removal drops grant same cycle; the code drops it one cycle after the synced request falls
// RULE21 - arbitration works in reset and boot
// RULE22 - grant hung when access waits on grant
// RULE23 - region control field layout
// RULE24 - bus lock ignores requests
// RULE25 - request passes two-stage synchroniser
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module emp_ctrl
    import emp_pkg::*;
#(
    parameter int ADDR_W = 22 // external address width
) (
    input wire logic clk_in, // peripheral clock
    input wire logic rst_in, // sync reset, active high
    input wire logic [3:0] reg_addr_in, // register index
    input wire logic [15:0] reg_wdata_in, // register write data
    input wire logic reg_wr_in, // register write strobe
    input wire logic reg_rd_in, // register read strobe
    output logic [15:0] reg_rdata_out, // read data, next cycle
    input wire logic req_valid_in, // core access request
    input wire emp_req_s req_in, // access descriptor
    output logic req_ready_out, // request accepted
    output logic core_stall_out, // core held off
    output logic [15:0] rd_data_out, // read return data
    output logic rd_valid_out, // read data pulse
    input wire logic boot_active_in, // boot loader running
    input wire logic ack_in, // external acknowledge
    input wire logic [15:0] data_pin_in, // data bus in
    output emp_pins_s pins_out, // pin values
    output logic pins_oe_out, // drive pins when high
    output logic output_clock_out, // region access clock
    input wire logic bus_request_n_in, // async bus request
    output logic bus_grant_n_out, // bus grant, low active
    output logic grant_hung_n_out // grant hung, low active
);
    // refuse address widths that the page decode cannot serve
    if (ADDR_W < 17 || ADDR_W > 22) begin : g_bad_addr_w
        $error("ADDR_W out of range");
    end

    // whole state in one struct
    typedef struct packed {
        emp_state_e st;
        logic [5:0][15:0] rctl;
        logic [3:0][7:0] page;
        logic lock;
        logic [15:0] rdata;
        emp_req_s cur;
        emp_pins_s pins;
        logic [4:0] div_cnt;
        logic [3:0] ws_cnt;
        logic req_s1;
        logic req_s2;
        logic grant;
        logic [4:0] mid;
        logic [15:0] rd_data;
        logic rd_valid;
        logic aclk;
    } emp_st_s;

    emp_st_s q_ff, nxt_q;

    // access clock ratio as a divider mask
    function automatic logic [4:0] div_mask(input logic [2:0] cds);
        logic [4:0] m;
        m = 5'h00;
        if (cds <= EMP_CDS_MAX) m = 5'((6'h01 << cds) - 6'h01); // RULE8
        else m = 5'h1F;
        return m;
    endfunction

    // address to bank select, one-hot low-active
    function automatic logic [3:0] bank_of(input logic [21:0] a,
                                          input logic [3:0][7:0] pg);
        logic [7:0] p;
        logic [3:0] s;
        p = a[ADDR_W-1 -: 8];
        s = 4'hF;
        if (a >= 22'h010000) begin // RULE10
            if (p >= pg[3]) s = 4'h7;
            else if (p >= pg[2]) s = 4'hB;
            else if (p >= pg[1]) s = 4'hD;
            else if (p >= pg[0]) s = 4'hE;
        end
        return s;
    endfunction

    logic [15:0] rc; // active region control
    logic [2:0] wcnt; // programmed count
    logic [1:0] wms; // active mode
    logic aedge; // one access clock tick
    logic cnt_done; // count elapsed
    logic done; // access ends this tick
    logic req_act; // synced request asserted
    logic ack_pend; // core access waiting on grant

    // access termination and state walk
    always_comb begin
        nxt_q = q_ff;
        nxt_q.rd_valid = 1'b0;
        nxt_q.req_s1 = ~bus_request_n_in; // RULE25
        nxt_q.req_s2 = q_ff.req_s1; // RULE25
        req_act = q_ff.req_s2 & ~q_ff.lock; // RULE24
        rc = q_ff.rctl[q_ff.cur.space];
        wms = rc[EMP_WMS_LSB +: 2];
        wcnt = q_ff.cur.write ? rc[EMP_WWC_LSB +: 3]
                              : rc[EMP_RWC_LSB +: 3]; // RULE1 RULE23
        if (wms == EMP_WMS_ACK && wcnt < EMP_ACK_MIN_WS)
            wcnt = EMP_ACK_MIN_WS; // RULE2
        aedge = (q_ff.div_cnt & div_mask(rc[EMP_CDS_LSB +: 3])) == 5'h00;
        cnt_done = q_ff.ws_cnt >= {1'b0, wcnt};
        unique case (wms)
            EMP_WMS_ACK: done = cnt_done & ack_in; // RULE2
            EMP_WMS_WAIT: done = cnt_done; // RULE3
            EMP_WMS_BOTH: done = cnt_done & ack_in; // RULE4
            EMP_WMS_EITHER: done = cnt_done | ack_in; // RULE5
        endcase
        ack_pend = req_valid_in & (q_ff.st == EMP_GRANT);
        req_ready_out = 1'b0;
        nxt_q.div_cnt = q_ff.div_cnt + 5'h01;
        if (aedge) nxt_q.aclk = ~q_ff.aclk;
        // register writes
        if (reg_wr_in) begin
            if (reg_addr_in <= EMP_REG_IO)
                nxt_q.rctl[reg_addr_in[2:0]] = reg_wdata_in; // RULE23
            else if (reg_addr_in == EMP_REG_PAGES10) begin
                nxt_q.page[0] = reg_wdata_in[7:0]; // RULE9
                nxt_q.page[1] = reg_wdata_in[15:8];
            end else if (reg_addr_in == EMP_REG_PAGES32) begin
                nxt_q.page[2] = reg_wdata_in[7:0];
                nxt_q.page[3] = reg_wdata_in[15:8];
            end else if (reg_addr_in == EMP_REG_CTL)
                nxt_q.lock = reg_wdata_in[EMP_BL_BIT]; // RULE24
        end
        // register reads
        nxt_q.rdata = 16'h0000;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                EMP_REG_BANK0, EMP_REG_BANK1, EMP_REG_BANK2,
                EMP_REG_BANK3, EMP_REG_BOOT, EMP_REG_IO:
                    nxt_q.rdata = q_ff.rctl[reg_addr_in[2:0]];
                EMP_REG_PAGES10: nxt_q.rdata = {q_ff.page[1], q_ff.page[0]};
                EMP_REG_PAGES32: nxt_q.rdata = {q_ff.page[3], q_ff.page[2]};
                EMP_REG_CTL: nxt_q.rdata = {15'h0000, q_ff.lock};
                EMP_REG_WSTAT: // RULE11
                    nxt_q.rdata[EMP_WPF_BIT] = q_ff.cur.write &
                        (q_ff.st == EMP_STROBE || q_ff.st == EMP_HOLD);
                EMP_REG_BSTAT: begin
                    nxt_q.rdata[EMP_BSY_LSB +: 2] = q_ff.grant ? EMP_BSY_OFF :
                        (q_ff.st == EMP_IDLE ? EMP_BSY_IDLE
                                             : EMP_BSY_ON); // RULE12
                    nxt_q.rdata[EMP_MID_LSB +: 5] = q_ff.mid; // RULE13
                    nxt_q.rdata[EMP_WPS_LSB +: 2] = 2'h0; // RULE14
                end
                default: nxt_q.rdata = 16'h0000; // unmapped reads zero
            endcase
        end
        // access sequencer and arbiter
        unique case (q_ff.st)
            EMP_IDLE: begin
                if (req_act) begin // RULE16 RULE21
                    nxt_q.st = EMP_GRANT;
                    nxt_q.grant = 1'b1;
                    nxt_q.mid = EMP_MID_EXT;
                end else if (req_valid_in) begin
                    req_ready_out = 1'b1; // RULE15 write posted here
                    nxt_q.cur = req_in;
                    nxt_q.st = EMP_STROBE;
                    nxt_q.ws_cnt = 4'h0;
                    nxt_q.div_cnt = 5'h01;
                    nxt_q.mid = EMP_MID_CORE;
                    nxt_q.pins.addr = req_in.addr;
                    nxt_q.pins.data = req_in.data;
                    nxt_q.pins.rd_n = req_in.write;
                    nxt_q.pins.wr_n = ~req_in.write;
                    nxt_q.pins.bank_sel_n = 4'hF;
                    nxt_q.pins.boot_sel_n = req_in.space != EMP_RGN_BOOT;
                    nxt_q.pins.io_sel_n = req_in.space != EMP_RGN_IO;
                    if (req_in.space < EMP_RGN_BOOT)
                        nxt_q.pins.bank_sel_n =
                            bank_of(req_in.addr, q_ff.page); // RULE10
                end
            end
            EMP_STROBE: if (aedge) begin
                if (done) begin // RULE18 RULE21 grant waits for this
                    nxt_q.pins.rd_n = 1'b1;
                    nxt_q.pins.wr_n = 1'b1;
                    if (!q_ff.cur.write) begin
                        nxt_q.rd_data = data_pin_in;
                        nxt_q.rd_valid = 1'b1;
                    end
                    if (q_ff.cur.write && rc[EMP_WHE_BIT])
                        nxt_q.st = EMP_HOLD; // RULE6 RULE7
                    else
                        nxt_q.st = EMP_GAP;
                end else if (q_ff.ws_cnt != 4'hF)
                    nxt_q.ws_cnt = q_ff.ws_cnt + 4'h1;
            end
            EMP_HOLD: if (aedge) nxt_q.st = EMP_GAP; // RULE6
            EMP_GAP: begin // RULE19 bus may go away between accesses
                nxt_q.pins.bank_sel_n = 4'hF;
                nxt_q.pins.boot_sel_n = 1'b1;
                nxt_q.pins.io_sel_n = 1'b1;
                nxt_q.st = EMP_IDLE;
                if (req_act) begin
                    nxt_q.st = EMP_GRANT;
                    nxt_q.grant = 1'b1;
                    nxt_q.mid = EMP_MID_EXT;
                end
            end
            EMP_GRANT: if (!req_act) begin // RULE20 RULE22
                nxt_q.st = EMP_IDLE;
                nxt_q.grant = 1'b0;
            end
        endcase
        if (rst_in) begin
            nxt_q.st = q_ff.grant ? q_ff.st : EMP_IDLE; // RULE21
        end
    end

    // state register
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            q_ff.rctl <= {6{EMP_RCTL_RST}};
            q_ff.page <= {EMP_PG3_RST, EMP_PG2_RST, EMP_PG1_RST,
                          EMP_PG0_RST}; // RULE9
            q_ff.lock <= 1'b0;
            q_ff.rdata <= 16'h0000;
            q_ff.cur <= '0;
            q_ff.pins <= '{addr: '0, data: '0, rd_n: 1'b1, wr_n: 1'b1,
                bank_sel_n: 4'hF, boot_sel_n: 1'b1, io_sel_n: 1'b1};
            q_ff.div_cnt <= 5'h00;
            q_ff.ws_cnt <= 4'h0;
            q_ff.req_s1 <= nxt_q.req_s1; // arbitration runs in reset
            q_ff.req_s2 <= nxt_q.req_s2;
            // only the second stage decides, so state and grant agree
            q_ff.st <= q_ff.req_s2 ? EMP_GRANT : EMP_IDLE; // RULE21
            q_ff.grant <= q_ff.req_s2; // RULE21
            q_ff.mid <= 5'h00;
            q_ff.rd_data <= 16'h0000;
            q_ff.rd_valid <= 1'b0;
            q_ff.aclk <= 1'b0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    // outputs
    assign reg_rdata_out = q_ff.rdata;
    assign pins_out = q_ff.pins;
    assign pins_oe_out = ~q_ff.grant; // RULE16 float while granted
    assign bus_grant_n_out = ~q_ff.grant;
    assign grant_hung_n_out = ~ack_pend; // RULE22
    assign core_stall_out = req_valid_in & ~req_ready_out; // RULE17
    assign rd_data_out = q_ff.rd_data;
    assign rd_valid_out = q_ff.rd_valid;
    assign output_clock_out = q_ff.aclk; // RULE8

    // checks
    sequence s_req_idle;
        req_act && q_ff.st == EMP_IDLE;
    endsequence
    grant_next_a: assert property (@(posedge clk_in) disable iff (rst_in)
        s_req_idle |=> !bus_grant_n_out && !pins_oe_out) // RULE16
        else $error("grant not given after idle request");
    grant_wait_a: assert property (@(posedge clk_in) disable iff (rst_in)
        q_ff.st == EMP_STROBE |=> bus_grant_n_out) // RULE18
        else $error("grant during access");
    release_a: assert property (@(posedge clk_in) disable iff (rst_in)
        q_ff.st == EMP_GRANT && !req_act |=> bus_grant_n_out) // RULE20
        else $error("grant held after release");
    hung_a: assert property (@(posedge clk_in) disable iff (rst_in)
        !grant_hung_n_out |-> !bus_grant_n_out) // RULE22
        else $error("hung without grant");
    lock_a: assert property (@(posedge clk_in) disable iff (rst_in)
        q_ff.lock && q_ff.st == EMP_IDLE |=> bus_grant_n_out) // RULE24
        else $error("grant while locked");
    sync_a: assert property (@(posedge clk_in) disable iff (rst_in)
        q_ff.req_s2 == $past(q_ff.req_s1)) // RULE25
        else $error("synchroniser broken");
    ack_mode_a: assert property (@(posedge clk_in) disable iff (rst_in)
        q_ff.st == EMP_STROBE && wms == EMP_WMS_ACK && !ack_in
        |=> q_ff.st == EMP_STROBE) // RULE2
        else $error("ack mode ended without ack");
    wait_mode_a: assert property (@(posedge clk_in) disable iff (rst_in)
        q_ff.st == EMP_STROBE && wms == EMP_WMS_WAIT && aedge && cnt_done
        |=> q_ff.st != EMP_STROBE) // RULE3
        else $error("wait mode overran count");
    hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
        q_ff.st == EMP_HOLD |-> pins_out.wr_n
            && pins_out.addr == q_ff.cur.addr) // RULE6
        else $error("hold cycle lost address");
endmodule
`default_nettype wire

// *** testbench/emp_mem_model.sv ***
// external memory and io device model facing the port pins
`timescale 1ns/1ps
`default_nettype none
module emp_mem_model
    import emp_pkg::*;
(
    input wire logic clk_in, // peripheral clock
    input wire emp_pins_s pins_in, // port pin values
    input wire logic oe_in, // port drives the pins
    input wire logic [7:0] ack_dly_in, // FF means never acknowledge
    output logic ack_out, // acknowledge to the port
    output logic [15:0] data_out, // data bus to the port
    output logic [15:0] wr_data_out // last data written
);
    logic strobe; // a strobe is low while driven
    logic rd_on; // read strobe low
    logic [7:0] cnt = 8'h00; // cycles since the strobe fell
    logic [15:0] last = 16'h0000; // last value we drove
    // pull-ups keep strobes high while the port floats them
    assign strobe = oe_in && !(pins_in.rd_n && pins_in.wr_n);
    assign rd_on = oe_in && !pins_in.rd_n;
    // slow device: ack only after the chosen delay
    assign ack_out = strobe && ack_dly_in != 8'hFF
        && cnt >= ack_dly_in;
    // a released bus shows the inverse, never stale data
    assign data_out = rd_on ? {pins_in.addr[7:0], 8'h5A} : ~last;
    // count strobe cycles, remember driven and written data
    always_ff @(posedge clk_in) begin
        cnt <= strobe ? cnt + 8'h01 : 8'h00;
        if (rd_on) begin
            last <= {pins_in.addr[7:0], 8'h5A};
        end
        if (oe_in && !pins_in.wr_n) begin
            wr_data_out <= pins_in.data;
        end
    end
endmodule
`default_nettype wire

// *** testbench/external_memory_port_ctrl_tb.sv ***
// self-checking bench for the external memory port controller
`timescale 1ns/1ps
`default_nettype none
module external_memory_port_ctrl_tb;
    import emp_pkg::*;
    logic clk_in = 1'b0; // 200 MHz clock
    logic rst_in = 1'b1; // sync reset
    logic [3:0] reg_addr = 4'h0; // register index
    logic [15:0] reg_wdata = 16'h0000; // register write data
    logic reg_wr = 1'b0; // register strobes
    logic reg_rd = 1'b0;
    logic req_valid = 1'b0; // core request
    emp_req_s req = '0; // access descriptor
    logic br_n = 1'b1; // bus request, low active
    logic boot_active = 1'b0; // boot flag, not exercised
    logic [7:0] ack_dly = 8'hFF; // model ack delay
    logic [15:0] reg_rdata, rd_data, mem_data, wr_seen, rdat, hold_data;
    logic req_ready, core_stall, rd_valid, ack, oe, oclk, bg_n, bgh_n;
    emp_pins_s pins; // pin values
    logic [21:0] hold_addr; // address one cycle after strobe end
    logic [5:0] sel; // {bank selects, boot, io} during strobe
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0; // timeout counter
    int len; // strobe length of the last access
    int base; // read length with no waitstates
    initial forever #2.5 clk_in = ~clk_in;
    emp_ctrl DUT (.clk_in(clk_in), .rst_in(rst_in),
        .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
        .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata),
        .req_valid_in(req_valid), .req_in(req), .req_ready_out(req_ready),
        .core_stall_out(core_stall), .rd_data_out(rd_data),
        .rd_valid_out(rd_valid), .boot_active_in(boot_active),
        .ack_in(ack), .data_pin_in(mem_data), .pins_out(pins),
        .pins_oe_out(oe), .output_clock_out(oclk),
        .bus_request_n_in(br_n), .bus_grant_n_out(bg_n),
        .grant_hung_n_out(bgh_n));
    emp_mem_model MEM (.clk_in(clk_in), .pins_in(pins), .oe_in(oe),
        .ack_dly_in(ack_dly), .ack_out(ack), .data_out(mem_data),
        .wr_data_out(wr_seen));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task automatic check_len(input int got, input int exp);
        tests_run++;
        if (got != exp) begin
            miscompares++;
            $display("wrong value at %0t: count %0d not %0d", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_in);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_in);
        reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rreg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_in);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_in);
        reg_rd <= 1'b0;
        @(negedge clk_in);
        d = reg_rdata;
    endtask
    function automatic logic [15:0] rctl(input int rw, ww, ms, cd, wh);
        return {4'h0, wh[0], cd[2:0], ms[1:0], ww[2:0], rw[2:0]};
    endfunction
    // one core access; request held until ready is seen at an edge
    task automatic access(input int sp, input logic wr, input logic [21:0] a);
        int n;
        @(posedge clk_in);
        req_valid <= 1'b1;
        req <= '{space: sp[2:0], write: wr, addr: a, data: a[15:0] ^ 16'h3C3C};
        n = 0;
        do begin
            @(negedge clk_in);
            n++;
        end while (!req_ready && n < 500);
        @(posedge clk_in);
        req_valid <= 1'b0;
        do @(negedge clk_in); while (pins.rd_n && pins.wr_n && n++ < 900);
        sel = {pins.bank_sel_n, pins.boot_sel_n, pins.io_sel_n};
        len = 0;
        while (!(pins.rd_n && pins.wr_n) && len < 3000) begin
            @(negedge clk_in);
            len++;
        end
        hold_addr = pins.addr;
        hold_data = pins.data;
        for (n = 0; !wr && !rd_valid && n < 10; n++) @(negedge clk_in);
        rdat = rd_data;
    endtask
    task automatic acc_len(input logic [7:0] dly, output int l);
        ack_dly <= dly;
        access(2, 1'b0, 22'h200000);
        l = len;
    endtask
    task automatic test_reset();
        logic [15:0] d;
        rreg(EMP_REG_BANK0, d);
        check(d, EMP_RCTL_RST);
        rreg(EMP_REG_PAGES10, d);
        check(d, {EMP_PG1_RST, EMP_PG0_RST});
        rreg(EMP_REG_PAGES32, d);
        check(d, {EMP_PG3_RST, EMP_PG2_RST});
        wreg(EMP_REG_BSTAT, 16'hFFFF); // read-only place, write ignored
        rreg(EMP_REG_BSTAT, d);
        check(d & 16'h0183, 16'(EMP_BSY_IDLE));
        rreg(EMP_REG_WSTAT, d);
        check(d & 16'h0100, 16'h0000);
        rreg(4'hF, d); // unmapped
        check(d, 16'h0000);
        $display("reset test done");
    endtask
    task automatic test_waits();
        int a, b;
        wreg(EMP_REG_BANK0, rctl(7, 0, 1, 0, 0)); // ack never comes
        access(0, 1'b0, 22'h010000);
        a = len;
        check(rdat, 16'h005A);
        access(0, 1'b1, 22'h010001);
        b = len;
        wreg(EMP_REG_BANK0, rctl(0, 3, 1, 0, 0));
        access(0, 1'b0, 22'h010000);
        base = len;
        access(0, 1'b1, 22'h010001);
        check_len(a - base, 7);
        check_len(len - b, 3);
        for (int d = 0; d < 6; d++) begin
            wreg(EMP_REG_BANK1, rctl(0, 0, 1, d, 0));
            access(1, 1'b0, 22'h100000);
            a = len;
            wreg(EMP_REG_BANK1, rctl(1, 0, 1, d, 0));
            access(1, 1'b0, 22'h100000);
            check_len(len - a, 1 << d);
        end
        // bank one now runs at 1:32: output clock toggles every tick
        @(negedge clk_in);
        b = oclk;
        while (oclk == b) @(negedge clk_in);
        for (a = 0; oclk != b && a < 200; a++) @(negedge clk_in);
        check_len(a, 32);
        $display("waitstate and divider test done");
    endtask
    task automatic test_ack_modes();
        int x, y;
        wreg(EMP_REG_BANK2, rctl(0, 0, 0, 0, 0));
        acc_len(8'h00, x);
        check_len(x, base + 2);
        acc_len(8'h05, x);
        acc_len(8'h08, y);
        check_len(y - x, 3);
        wreg(EMP_REG_BANK2, rctl(3, 0, 2, 0, 0));
        acc_len(8'h00, x);
        check_len(x, base + 3);
        acc_len(8'h0A, x);
        acc_len(8'h0C, y);
        check_len(y - x, 2);
        wreg(EMP_REG_BANK2, rctl(7, 0, 3, 0, 0));
        acc_len(8'hFF, x);
        check_len(x, base + 7);
        acc_len(8'h02, x);
        acc_len(8'h04, y);
        check_len(y - x, 2);
        $display("ack mode test done");
    endtask
    task automatic test_hold_banks();
        logic [21:0] ad [6] = '{22'h010000, 22'h100000, 22'h200000,
            22'h3FFFFF, 22'h010000, 22'h010000};
        logic [5:0] ex [6] = '{6'b111011, 6'b110111, 6'b101111,
            6'b011111, 6'b111101, 6'b111110};
        wreg(EMP_REG_BANK3, rctl(0, 1, 2, 0, 1)); // both mode, write hold
        ack_dly <= 8'h00;
        access(3, 1'b1, 22'h3000A5);
        check(hold_addr[15:0], 16'h00A5);
        check(hold_data, 16'h3C99);
        @(negedge clk_in);
        check(16'(pins.bank_sel_n), 16'h0007);
        check(wr_seen, 16'h3C99);
        for (int i = 0; i < 6; i++) begin
            access(i, 1'b0, ad[i]);
            check(16'(sel), 16'(ex[i]));
        end
        wreg(EMP_REG_PAGES10, 16'h2001); // bank one now starts at page 20
        access(1, 1'b0, 22'h080000);
        check(16'(sel), 16'h0037);
        $display("hold and bank test done");
    endtask
    task automatic test_bus();
        logic [15:0] d;
        int n;
        wreg(EMP_REG_BANK0, rctl(0, 7, 1, 3, 0)); // slow posted write
        fork
            access(0, 1'b1, 22'h010002);
        join_none
        for (n = 0; pins.wr_n && n < 200; n++) @(negedge clk_in);
        check(16'(core_stall), 16'h0000);
        rreg(EMP_REG_WSTAT, d);
        check(d & 16'h0100, 16'h0100);
        rreg(EMP_REG_BSTAT, d);
        check(d & 16'h007F, {9'h0, EMP_MID_CORE, EMP_BSY_ON});
        @(posedge clk_in);
        br_n <= 1'b0;
        while (!pins.wr_n) begin
            @(negedge clk_in);
            check(16'(bg_n), 16'h0001);
        end
        wait fork;
        for (n = 0; bg_n && n < 10; n++) @(negedge clk_in);
        check(16'(oe), 16'h0000);
        rreg(EMP_REG_BSTAT, d);
        check(d & 16'h007F, {9'h0, EMP_MID_EXT, EMP_BSY_OFF});
        rreg(EMP_REG_WSTAT, d);
        check(d & 16'h0100, 16'h0000);
        @(posedge clk_in);
        req_valid <= 1'b1;
        req <= '{space: 3'h0, write: 1'b0, addr: 22'h010004, data: 16'h0};
        repeat (3) @(negedge clk_in);
        check({bgh_n, req_ready, core_stall}, 16'h0001);
        @(posedge clk_in);
        br_n <= 1'b1;
        for (n = 0; !bg_n && n < 10; n++) @(negedge clk_in);
        check({bgh_n, bg_n, oe}, 16'h0007);
        access(0, 1'b0, 22'h010004);
        check(rdat, 16'h045A);
        @(posedge clk_in);
        br_n <= 1'b0;
        for (n = 0; bg_n && n < 20; n++) @(negedge clk_in);
        check_len(n, 4);
        @(posedge clk_in);
        br_n <= 1'b1;
        wreg(EMP_REG_CTL, 16'h0001); // lock the bus
        br_n <= 1'b0;
        repeat (12) @(negedge clk_in);
        check(16'(bg_n), 16'h0001);
        @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (6) @(negedge clk_in);
        check(16'(bg_n), 16'h0000);
        @(posedge clk_in);
        br_n <= 1'b1;
        rst_in <= 1'b0;
        $display("bus master test done");
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // hang guard, well above the expected run length
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            miscompares++;
            complete_run();
        end
    end
    initial begin
        repeat (8) @(posedge clk_in);
        rst_in <= 1'b0;
        test_reset();
        test_waits();
        test_ack_modes();
        test_hold_banks();
        test_bus();
        complete_run();
    end
endmodule
`default_nettype wire
